// [core/adc_consts.svh]
// Named constants for the converter control block: counts, codes and encodings.
// Assumes inclusion by bare name from any design file that needs a figure.
`ifndef ADC_CONSTS_SVH
`define ADC_CONSTS_SVH

// =====================================================================
// Conversion lengths in converter clock cycles.
`define FIRST_CONV_CYCLES  16'd25
`define NORMAL_CONV_CYCLES 16'd13

// =====================================================================
// Result codes and limits.
`define RESULT_RESET   10'h000
`define SE_MAX_CODE    10'h3ff
`define DIFF_MAX_CODE  10'h1ff
`define DIFF_MIN_CODE  10'h200
`define SE_RAW_MAX     11'sh3ff
`define DIFF_RAW_MAX   11'sh1ff
`define DIFF_RAW_MIN   -11'sh200
`define RESULT_MSB     9
`define BYTE_RESET     8'h00
`define LEFT_PAD       6'h00
`define RIGHT_PAD      6'h00

// =====================================================================
// Sleep mode encodings and channel select range of differential pairs.
`define SLEEP_MODE_IDLE   3'h0
`define SLEEP_MODE_NOISE  3'h1
`define DIFF_SEL_FIRST    5'h08
`define DIFF_SEL_LAST     5'h1d
`define COUNT_ONE         16'd1

`endif

// [core/adc_pkg.sv]
// Types shared by the converter control block.
// Assumes the constants header is compiled alongside it.
package adc_pkg;
	// =====================================================================
	// Conversion sequencer states, Gray coded along idle, wait, convert.
	typedef enum logic [1:0] {
		ST_IDLE      = 2'b00,
		ST_HALT_WAIT = 2'b01,
		ST_CONVERT   = 2'b11
	} conv_state_type;

	typedef logic [2:0] sleep_mode_type;
	typedef logic [9:0] result_code_type;
	typedef logic signed [10:0] raw_sample_type;
endpackage

// [core/result_format.sv]
// Places a 10-bit result code into the two result bytes, right or left justified.
// Assumes the caller registers the outputs; this module is purely combinational.
`timescale 1ns/1ps
`include "adc_consts.svh"

module result_format (
	input  wire logic [9:0] code,
	input  wire logic       left,
	output logic      [7:0] low_byte,
	output logic      [7:0] high_byte
);
	// =====================================================================
	// Justification mux; the select is applied live so a change shows at once.
	always_comb begin
		if (left) begin
			high_byte = code[9:2];                   // [R14]
			low_byte  = {code[1:0], `LEFT_PAD};      // [R14]
		end else begin
			high_byte = {`RIGHT_PAD, code[9:8]};     // [R14]
			low_byte  = code[7:0];                   // [R14]
		end
	end
endmodule

// [core/conv_timer.sv]
// Counts the length of one conversion and flags its end.
// Assumes start is never raised while busy and abort wins over everything.
`timescale 1ns/1ps
`include "adc_consts.svh"

module conv_timer #(
	parameter int CLK_DIV = 2
) (
	input  wire logic mclk,
	input  wire logic rst,
	input  wire logic start,
	input  wire logic abort,
	input  wire logic extended,
	output logic      busy,
	output logic      done
);
	logic [15:0] count_reg;
	logic [15:0] load_value;

	// =====================================================================
	// The first conversion after enabling runs long to let the analog side settle.
	assign load_value = extended ? 16'(`FIRST_CONV_CYCLES * CLK_DIV) : 16'(`NORMAL_CONV_CYCLES * CLK_DIV);

	// Down counter; busy falls and done pulses on the same edge.
	always_ff @(posedge mclk) begin
		if (rst || abort) begin
			busy      <= 1'b0;
			count_reg <= 16'h0000;
		end else if (start) begin
			busy      <= 1'b1;
			count_reg <= load_value;
		end else if (busy) begin
			busy      <= (count_reg != `COUNT_ONE);
			count_reg <= count_reg - `COUNT_ONE;
		end
	end

	// A one-cycle completion pulse; an aborted conversion never reports done.
	always_ff @(posedge mclk) begin
		if (rst || abort) begin
			done <= 1'b0;
		end else begin
			done <= busy && !start && (count_reg == `COUNT_ONE);
		end
	end
endmodule

// [core/adc_sleep_ctrl.sv]
// Converter control: sleep-started conversion, completion flag, wake-up and result formatting.
// Assumes synchronous single-cycle pulses from the CPU and an analog core that presents
// a raw ideal code on analog_sample during the cycle in which the conversion ends.
`timescale 1ns/1ps
`include "adc_consts.svh"

// Summary of operation
// R01: Software enables converter, keeps it idle, single mode, interrupt enabled before sleeping.
// R02: Entering idle or noise-reduction sleep starts a conversion once the CPU clock halts.
// R03: Conversion completion with interrupt enabled wakes the sleeping CPU.
// R04: Another interrupt may wake first; completion still raises the interrupt request.
// R05: After waking, the CPU stays active until the next sleep command.
// R06: Other sleep modes never disable the converter by themselves.
// R07: Software should toggle enable after such sleep for a valid differential result.
// R08: Digital outputs on shared converter pins must not toggle during a conversion.
// R09: With the done flag high the result bytes hold the finished result.
// R10: Single-ended result is unsigned, from 0x000 up to 0x3FF.
// R11: Differential result is two's complement from 0x200 to 0x1FF.
// R12: The result top bit is the sign of a differential result.
// R13: Differential codes saturate at 0x1FF and 0x200.
// R14: Right justify puts bits 7:0 low; left justify puts bits 9:2 high.
// R15: Changing justification changes the presented bytes at once, even mid-conversion.
// R16: Sleep start only happens when enabled, idle and in single-conversion operation.
module adc_sleep_ctrl #(
	parameter int CLK_DIV = 2
) (
	input  wire logic                    mclk,
	input  wire logic                    rst,
	input  wire logic                    converter_enable_bit,
	input  wire logic                    start_conversion,
	input  wire logic                    free_running_select,
	input  wire logic                    conv_irq_enable,
	input  wire logic                    justify_left_select,
	input  wire logic [4:0]              input_select_register,
	input  wire logic                    sleep_command,
	input  wire adc_pkg::sleep_mode_type sleep_mode,
	input  wire logic                    other_wake_irq,
	input  wire logic                    done_flag_clear,
	input  wire adc_pkg::raw_sample_type analog_sample,
	output logic [7:0]                   result_low_byte,
	output logic [7:0]                   result_high_byte,
	output logic                         result_sign_bit,
	output logic                         conversion_done_flag,
	output logic                         conv_irq_request,
	output logic                         converter_busy,
	output logic                         cpu_clock_halt,
	output logic                         cpu_wake
);
	import adc_pkg::*;

	conv_state_type  conv_state_reg;
	conv_state_type  conv_state_next;
	result_code_type result_code_reg;
	result_code_type result_code_next;
	logic            diff_lock_reg;
	logic            extended_reg;
	logic            sleep_auto_ok;
	logic            mode_allows_auto;
	logic            timer_start;
	logic            timer_done;
	logic            wake_next;
	logic            flag_next;
	logic [7:0]      low_next;
	logic [7:0]      high_next;

	// =====================================================================
	// Decoding helpers.

	// True for channel selections that form a differential pair.
	function automatic logic is_differential(input logic [4:0] sel);
		is_differential = (sel >= `DIFF_SEL_FIRST) && (sel <= `DIFF_SEL_LAST);
	endfunction

	// Clamps the analog core's ideal code into the 10-bit output range.
	function automatic result_code_type saturate(input raw_sample_type raw, input logic diff);
		if (diff) begin
			if (raw > `DIFF_RAW_MAX) begin
				saturate = `DIFF_MAX_CODE;                      // [R13]
			end else if (raw < `DIFF_RAW_MIN) begin
				saturate = `DIFF_MIN_CODE;                      // [R13]
			end else begin
				saturate = raw[9:0];                            // [R11]
			end
		end else begin
			if (raw[10] || raw > `SE_RAW_MAX) begin
				saturate = raw[10] ? `RESULT_RESET : `SE_MAX_CODE; // [R10]
			end else begin
				saturate = raw[9:0];                            // [R10]
			end
		end
	endfunction

	// =====================================================================
	// Start decisions.

	// Deeper sleep modes leave the converter alone; only these two may auto-start.
	assign mode_allows_auto = (sleep_mode == `SLEEP_MODE_IDLE) || (sleep_mode == `SLEEP_MODE_NOISE);
	assign sleep_auto_ok    = sleep_command && mode_allows_auto && converter_enable_bit
	                          && !free_running_select && (conv_state_reg == ST_IDLE); // [R16]

	// Conversion begins on a software start, on the halted CPU clock, or on free-running restart.
	always_comb begin
		timer_start = 1'b0;
		case (conv_state_reg)
			ST_IDLE:      timer_start = converter_enable_bit && start_conversion && !sleep_auto_ok;
			ST_HALT_WAIT: timer_start = converter_enable_bit && cpu_clock_halt;          // [R02]
			ST_CONVERT:   timer_start = converter_enable_bit && timer_done && free_running_select;
			default:      timer_start = 1'b0;
		endcase
	end

	// =====================================================================
	// Sequencer next state; disabling the converter aborts from any state.
	always_comb begin
		conv_state_next = conv_state_reg;
		case (conv_state_reg)
			ST_IDLE: begin
				if (sleep_auto_ok) begin
					conv_state_next = ST_HALT_WAIT;                     // [R16]
				end else if (timer_start) begin
					conv_state_next = ST_CONVERT;
				end
			end
			ST_HALT_WAIT: begin
				if (timer_start) begin
					conv_state_next = ST_CONVERT;                       // [R02]
				end
			end
			ST_CONVERT: begin
				if (timer_done && !timer_start) begin
					conv_state_next = ST_IDLE;
				end
			end
			default: conv_state_next = ST_IDLE;
		endcase
		if (!converter_enable_bit) begin
			conv_state_next = ST_IDLE;
		end
	end

	// Sequencer state register.
	always_ff @(posedge mclk) begin
		if (rst) begin
			conv_state_reg <= ST_IDLE;
		end else begin
			conv_state_reg <= conv_state_next;
		end
	end

	// Channel type is locked at the start so a mid-conversion select change cannot corrupt coding.
	always_ff @(posedge mclk) begin
		if (rst) begin
			diff_lock_reg <= 1'b0;
		end else if (timer_start) begin
			diff_lock_reg <= is_differential(input_select_register);
		end
	end

	// The first conversion after enabling is extended; re-arms whenever the converter is off.
	always_ff @(posedge mclk) begin
		if (rst || !converter_enable_bit) begin
			extended_reg <= 1'b1;
		end else if (timer_start) begin
			extended_reg <= 1'b0;
		end
	end

	conv_timer #(
		.CLK_DIV (CLK_DIV)
	) u_timer (
		.mclk     (mclk),
		.rst      (rst),
		.start    (timer_start),
		.abort    (!converter_enable_bit),   // [R06]
		.extended (extended_reg),
		.busy     (converter_busy),
		.done     (timer_done)
	);

	// =====================================================================
	// Done flag and interrupt request; a completion in the clearing cycle wins.
	assign flag_next = timer_done || (conversion_done_flag && !done_flag_clear);

	always_ff @(posedge mclk) begin
		if (rst) begin
			conversion_done_flag <= 1'b0;
			conv_irq_request     <= 1'b0;
		end else begin
			conversion_done_flag <= flag_next;                            // [R09]
			conv_irq_request     <= flag_next && conv_irq_enable;         // [R04]
		end
	end

	// =====================================================================
	// CPU clock halt and wake; nothing but a sleep command halts it again.
	assign wake_next = cpu_clock_halt && (other_wake_irq || (timer_done && conv_irq_enable)); // [R03] [R04]

	always_ff @(posedge mclk) begin
		if (rst) begin
			cpu_clock_halt <= 1'b0;
			cpu_wake       <= 1'b0;
		end else begin
			cpu_wake <= wake_next;
			if (sleep_command) begin
				cpu_clock_halt <= 1'b1;
			end else if (wake_next) begin
				cpu_clock_halt <= 1'b0;                                 // [R05]
			end
		end
	end

	// =====================================================================
	// Result capture and presentation; bytes land on the same edge as the flag.
	assign result_code_next = timer_done ? saturate(analog_sample, diff_lock_reg) : result_code_reg;

	result_format u_format (
		.code      (result_code_next),
		.left      (justify_left_select),   // [R14]
		.low_byte  (low_next),
		.high_byte (high_next)
	);

	// The bytes are re-formatted every cycle, so the justify select takes effect at once.
	always_ff @(posedge mclk) begin
		if (rst) begin
			result_code_reg  <= `RESULT_RESET;
			result_low_byte  <= `BYTE_RESET;
			result_high_byte <= `BYTE_RESET;
			result_sign_bit  <= 1'b0;
		end else begin
			result_code_reg  <= result_code_next;                       // [R09]
			result_low_byte  <= low_next;                               // [R15]
			result_high_byte <= high_next;                              // [R15]
			result_sign_bit  <= result_code_next[`RESULT_MSB];          // [R12]
		end
	end

	// =====================================================================
	// Checks.
	a_sleep_start_halt: assert property (@(posedge mclk) disable iff (rst) // [R02]
		(conv_state_reg == ST_HALT_WAIT && cpu_clock_halt && converter_enable_bit) |=> converter_busy)
		else $error("Conversion did not start after the CPU clock halted.");

	a_done_wakes_cpu: assert property (@(posedge mclk) disable iff (rst) // [R03]
		(timer_done && conv_irq_enable && cpu_clock_halt && !sleep_command) |=> (cpu_wake && !cpu_clock_halt))
		else $error("Completion did not wake the sleeping CPU.");

	a_irq_after_wake: assert property (@(posedge mclk) disable iff (rst) // [R04]
		(timer_done && conv_irq_enable) |=> (conv_irq_request && conversion_done_flag))
		else $error("Completion did not raise the interrupt request.");

	a_stays_active: assert property (@(posedge mclk) disable iff (rst) // [R05]
		(!cpu_clock_halt && !sleep_command) |=> !cpu_clock_halt)
		else $error("CPU clock halted without a sleep command.");

	a_no_self_disable: assert property (@(posedge mclk) disable iff (rst) // [R06]
		(converter_busy && sleep_command && !mode_allows_auto && converter_enable_bit && !timer_done)
		|=> (converter_busy || timer_done))
		else $error("Conversion stopped on entry to a deep sleep mode.");

	a_result_with_flag: assert property (@(posedge mclk) disable iff (rst) // [R09]
		timer_done |=> (conversion_done_flag
		&& result_code_reg == saturate($past(analog_sample), $past(diff_lock_reg))))
		else $error("Result not present when the done flag rose.");

	// An 11-bit signed sample cannot exceed full scale, so the reachable clamp is the one below ground.
	a_single_clamp: assert property (@(posedge mclk) disable iff (rst) // [R10]
		(timer_done && !diff_lock_reg && analog_sample[10])
		|=> result_code_reg == `RESULT_RESET)
		else $error("Single-ended result did not clamp to ground.");

	a_diff_passes: assert property (@(posedge mclk) disable iff (rst) // [R11]
		(timer_done && diff_lock_reg && analog_sample <= `DIFF_RAW_MAX && analog_sample >= `DIFF_RAW_MIN)
		|=> result_code_reg == $past(analog_sample[9:0]))
		else $error("Differential in-range code was altered.");

	a_diff_clamp: assert property (@(posedge mclk) disable iff (rst) // [R13]
		(timer_done && diff_lock_reg && analog_sample < `DIFF_RAW_MIN) |=> result_code_reg == `DIFF_MIN_CODE)
		else $error("Differential result did not clamp to negative full scale.");

	a_sign_in_high: assert property (@(posedge mclk) disable iff (rst) // [R12]
		##1 (result_sign_bit == ($past(justify_left_select) ? result_high_byte[7] : result_high_byte[1])))
		else $error("Sign bit disagrees with the high result byte.");

	a_justify_now: assert property (@(posedge mclk) disable iff (rst) // [R15]
		($changed(justify_left_select) && !timer_done) |=> (result_low_byte ==
		($past(justify_left_select) ? {result_code_reg[1:0], `LEFT_PAD} : result_code_reg[7:0])))
		else $error("Justification change did not show on the next cycle.");

	a_no_auto_start: assert property (@(posedge mclk) disable iff (rst) // [R16]
		(sleep_command && conv_state_reg == ST_IDLE && (free_running_select || !converter_enable_bit))
		|=> conv_state_reg != ST_HALT_WAIT)
		else $error("Sleep start taken while not allowed.");

	c_sleep_wake: cover property (@(posedge mclk) disable iff (rst)
		conv_state_reg == ST_HALT_WAIT ##[1:200] (cpu_wake && conv_irq_request));
	c_other_wake: cover property (@(posedge mclk) disable iff (rst)
		(converter_busy && other_wake_irq && cpu_clock_halt) ##[1:200] timer_done);
	c_left_result: cover property (@(posedge mclk) disable iff (rst)
		conversion_done_flag && justify_left_select && result_sign_bit);
endmodule

// [sim/cpu_sleep_model.sv]
// Behavioural model of the CPU core and its sleep and interrupt controller beside the converter.
// Assumes the bench calls its tasks one at a time, 1 ns after a rising edge of mclk.
`timescale 1ns/1ps

module cpu_sleep_model (
	input  wire logic               mclk,
	input  wire logic               rst,
	input  wire logic               cpu_wake,
	output adc_pkg::sleep_mode_type sleep_mode,
	output logic                    sleep_command,
	output logic                    other_wake_irq,
	output logic                    done_flag_clear,
	output int                      wake_count
);
	import adc_pkg::*;

	// =====================================================================
	// Requests idle low; the mode lines carry junk when no sleep is issued.
	initial begin
		sleep_mode = 3'h7;
		sleep_command = 1'b0;
		other_wake_irq = 1'b0;
		done_flag_clear = 1'b0;
	end

	// Wake-ups are counted so that a double wake is not mistaken for one.
	always_ff @(posedge mclk) begin
		if (rst) begin
			wake_count <= 0;
		end else if (cpu_wake) begin
			wake_count <= wake_count + 1;
		end
	end

	// One sleep instruction; the bench readies the converter beforehand.
	task automatic enter_sleep(input sleep_mode_type m);
		sleep_mode = m;
		sleep_command = 1'b1;
		@(posedge mclk);
		#1;
		sleep_command = 1'b0;
		sleep_mode = ~m;
	endtask

	// Another interrupt source asks for a wake-up for one cycle.
	task automatic raise_other();
		other_wake_irq = 1'b1;
		@(posedge mclk);
		#1;
		other_wake_irq = 1'b0;
	endtask

	// The handler acknowledges the completion flag.
	task automatic ack_done();
		done_flag_clear = 1'b1;
		@(posedge mclk);
		#1;
		done_flag_clear = 1'b0;
	endtask
endmodule

// [sim/adc_sleep_ctrl_tb.sv]
// Self-checking bench for the converter control block: result formats, sleep start, wake-up.
// Assumes design files, package and the CPU model are compiled first; CLK_DIV is 1 for short runs.
`timescale 1ns/1ps

module adc_sleep_ctrl_tb;
	import adc_pkg::*;

	typedef struct {
		logic [4:0]      sel;
		raw_sample_type  raw;
		result_code_type code;
	} row_type;

	logic           mclk = 1'b0;
	logic           rst = 1'b1;
	logic           enable = 1'b0;
	logic           start = 1'b0;
	logic           free_run = 1'b0;
	logic           irq_en = 1'b0;
	logic           justify = 1'b0;
	logic [4:0]     sel = 5'h00;
	raw_sample_type sample = 11'sh000;
	sleep_mode_type mode;
	logic           sleep_cmd, other_irq, flag_clr;
	logic [7:0]     low_b, high_b;
	logic           sign_b, flag, irq_req, busy, halt, wake;
	int             wakes, n;
	int             miscompares = 0;
	int             tests_run = 0;
	int             cycles = 0;
	row_type        rows [10];

	// =====================================================================
	// Clock at 40 MHz; the ceiling is far above the roughly 300 cycles the tests need.
	always #12.5 mclk = ~mclk;
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			$display("[ERR] %0t run did not finish in time", $time);
			finish_test();
		end
	end

	adc_sleep_ctrl #(.CLK_DIV(1)) i_adc_sleep_ctrl (
		.mclk(mclk), .rst(rst), .converter_enable_bit(enable), .start_conversion(start),
		.free_running_select(free_run), .conv_irq_enable(irq_en), .justify_left_select(justify),
		.input_select_register(sel), .sleep_command(sleep_cmd), .sleep_mode(mode),
		.other_wake_irq(other_irq), .done_flag_clear(flag_clr), .analog_sample(sample),
		.result_low_byte(low_b), .result_high_byte(high_b), .result_sign_bit(sign_b),
		.conversion_done_flag(flag), .conv_irq_request(irq_req), .converter_busy(busy),
		.cpu_clock_halt(halt), .cpu_wake(wake));

	cpu_sleep_model i_cpu_sleep_model (
		.mclk(mclk), .rst(rst), .cpu_wake(wake), .sleep_mode(mode), .sleep_command(sleep_cmd),
		.other_wake_irq(other_irq), .done_flag_clear(flag_clr), .wake_count(wakes));

	// =====================================================================
	// Helpers; every drive happens 1 ns after a rising edge.
	task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
		tests_run++;
		if (seen !== want) begin
			miscompares++;
			$display("[ERR] %0t %s: seen %h want %h", $time, what, seen, want);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) begin
			@(posedge mclk);
			#1;
		end
	endtask

	// Bounded wait; k comes back as the edges after the call up to the one that raises the flag.
	task automatic wait_flag(output int k);
		k = 0;
		while (flag !== 1'b1 && k < 80) begin
			tick(1);
			k++;
		end
	endtask

	task automatic sw_convert(output int k);
		start = 1'b1;
		tick(1);
		start = 1'b0;
		wait_flag(k);
	endtask

	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// =====================================================================
	// Table of codes first, then sleep entry, foreign wake and the refused starts.
	initial begin
		rows = '{'{5'h00, 11'sh000, 10'h000},
			'{5'h07, 11'sd1023, 10'h3ff},
			'{5'h1e, -11'sd5, 10'h000},
			'{5'h0d, -11'sd400, 10'h270},
			'{5'h08, 11'sd511, 10'h1ff},
			'{5'h1d, 11'sd512, 10'h1ff},
			'{5'h10, -11'sd512, 10'h200},
			'{5'h1c, -11'sd600, 10'h200},
			'{5'h09, -11'sd1, 10'h3ff},
			'{5'h19, 11'sd1, 10'h001}};
		tick(2);
		rst = 1'b0;
		check({14'h0, halt, busy}, 16'h0, "idle after reset");
		$display("Test reset done");
		enable = 1'b1;
		foreach (rows[i]) begin
			sel = rows[i].sel;
			sample = rows[i].raw;
			justify = 1'b0;
			sw_convert(n);
			check(16'(n), (i == 0) ? 16'd26 : 16'd14, "flag latency");
			check({high_b, low_b}, {6'h00, rows[i].code}, "right justified");
			check(16'(sign_b), 16'(rows[i].code[9]), "sign bit");
			justify = 1'b1;
			tick(2);
			check({high_b, low_b}, {rows[i].code, 6'h00}, "left justified");
			i_cpu_sleep_model.ack_done();
		end
		$display("Test result table done");
		sel = 5'h00;
		sample = 11'sh155; // Held still while the conversion runs.
		justify = 1'b0;
		irq_en = 1'b1;
		i_cpu_sleep_model.enter_sleep(3'h1);
		tick(1);
		check(16'(halt), 16'h1, "halt after sleep");
		tick(1);
		check(16'(busy), 16'h1, "sleep started conversion");
		n = 0;
		while (wake !== 1'b1 && n < 80) begin
			tick(1);
			n++;
		end
		check(16'(n), 16'd13, "wake latency");
		check({13'h0, flag, irq_req, halt}, 16'h6, "woken by completion");
		tick(20);
		check({14'h0, halt, wake}, 16'h0, "stays active");
		check({high_b, low_b}, 16'h0155, "sleep result");
		$display("Test noise sleep done");
		i_cpu_sleep_model.ack_done();
		i_cpu_sleep_model.enter_sleep(3'h0);
		tick(4);
		i_cpu_sleep_model.raise_other();
		check({12'h0, wake, halt, busy, flag}, 16'ha, "foreign wake first");
		wait_flag(n);
		check({14'h0, irq_req, halt}, 16'h2, "request still raised");
		$display("Test foreign wake done");
		for (int c = 0; c < 3; c++) begin
			i_cpu_sleep_model.ack_done();
			enable = (c != 0);
			free_run = (c == 1);
			i_cpu_sleep_model.enter_sleep((c == 2) ? 3'h2 : 3'h1);
			tick(3);
			check({14'h0, halt, busy}, 16'h2, "no sleep start");
			i_cpu_sleep_model.raise_other();
		end
		free_run = 1'b0;
		enable = 1'b0;
		tick(1);
		enable = 1'b1;
		sel = 5'h0d;
		sample = -11'sd400;
		// A deep sleep taken mid-conversion must leave it running; n counts from the edge after the sleep instruction.
		start = 1'b1;
		tick(1);
		start = 1'b0;
		i_cpu_sleep_model.enter_sleep(3'h2);
		wait_flag(n);
		check(16'(n), 16'd25, "extended after re-enable");
		check({high_b, low_b}, 16'h0270, "valid after deep sleep");
		tick(1);
		check(16'(halt), 16'h0, "woken after deep sleep");
		check(16'(wakes), 16'd6, "one wake per sleep");
		$display("Test refused starts done");
		finish_test();
	end
endmodule
